/* File: verilog/ddr_dev_pkg.sv */
/*
  constants, field positions and state types shared by the command
  side of the memory device model and its per-bank tracker.
  assumes a single core clock of 25 MHz that oversamples every pin.
*/
`default_nettype none
// How it works
// - auto precharge chosen per command, never kept
// - auto precharge starts at earliest legal point
// - lockout: auto precharge waits for prefetch and ras
// - burst stop ends latest non-autoprecharge read
// - refresh address comes from internal counter
// - refresh with clock enable falling enters self refresh
// - dll off in self refresh, relock after exit
// - banks open independently; controller spaces activates
// - data follows cas latency, then every edge
// - strobe preamble low, last element strobe low
// - data and strobe released after burst
// - next read joins or truncates without gap
// - read accepted at every rising clock edge
// - command decoded from select and strobe levels
// - address bit ten high selects auto precharge

package ddr_dev_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CORE_NS = 40;          // core clock period
  localparam int T_RAS_NS = 40;         // least active to precharge
  localparam int T_RP_NS = 15;          // least precharge time
  localparam int REF_INTERVAL_US = 7800; // longest average refresh gap
  localparam int RAS_RAW = (T_RAS_NS + CORE_NS - 1) / CORE_NS;
  localparam int RAS_CYC = (RAS_RAW > 0) ? RAS_RAW : 1;
  localparam int RP_RAW = (T_RP_NS + CORE_NS - 1) / CORE_NS;
  localparam int RP_CYC = (RP_RAW > 0) ? RP_RAW : 1;
  localparam int REF_TICK_CYC = REF_INTERVAL_US * 1000 / CORE_NS;
  localparam int DLL_RELOCK_CK = 200;   // link clock rises to relock

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int DQ_W = 8;
  localparam int AP_BIT = 10;           // auto precharge / all banks

  // ------------------------------------------------------------
  // command codes {cs_n, ras_n, cas_n, we_n}
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_AREF = 4'h1;

  // ------------------------------------------------------------
  // positions in the sampled pin vector
  // ------------------------------------------------------------
  localparam int PIN_W = 21;
  localparam int PIN_CK = 20;
  localparam int PIN_CKE = 19;
  localparam int PIN_CMD = 18;          // msb of the four strobes
  localparam int PIN_BA = 13;           // lsb of bank address
  localparam int PIN_ADDR = 0;          // lsb of address

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {BANK_IDLE, BANK_ACTIVE, BANK_PRECH} bank_st_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_SREF, PWR_RELOCK} pwr_st_t;

endpackage
`default_nettype wire

/* File: verilog/bank_tracker.sv */
/*
  per-bank row state: idle, active with its open row, or precharging.
  assumes commands arrive as one-cycle pulses on the core clock and
  that the controller keeps its own spacing between commands.
*/
`default_nettype none
module bank_tracker
  import ddr_dev_pkg::*;
#(
  parameter int BL = 4 // burst length in elements
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ck_rise,
  input wire logic i_act,
  input wire logic i_pre,
  input wire logic i_pre_all,
  input wire logic i_ap,
  input wire logic [BANK_W-1:0] i_bank,
  input wire logic [ROW_W-1:0] i_row,
  output wire logic [NBANK-1:0] o_open,
  output wire logic [NBANK*ROW_W-1:0] o_rows
);

  localparam int APW = $clog2(BL / 2 + 1);
  localparam int RASW = $clog2(RAS_CYC + 1);
  localparam int RPW = $clog2(RP_CYC + 1);
  localparam logic [APW-1:0] AP_CK = APW'(BL / 2); // prefetch span

  // ------------------------------------------------------------
  // one copy of the bank logic per bank
  // ------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NBANK; b = b + 1) begin : g_bank
      bank_st_t st_r;              // bank state
      logic [ROW_W-1:0] row_r;     // open row
      logic [RASW-1:0] ras_r;      // cycles since activate
      logic [RPW-1:0] rp_r;        // cycles into precharge
      logic ap_r;                  // auto precharge armed
      logic [APW-1:0] apc_r;       // link rises left in prefetch
      logic hit;
      logic ras_ok;

      assign hit = (i_bank == BANK_W'(b));
      assign ras_ok = (ras_r == RASW'(RAS_CYC));

      // state walk; banks move independently
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          st_r <= BANK_IDLE;
        end else begin
          case (st_r)
            BANK_IDLE: begin
              if (i_act && hit) begin
                st_r <= BANK_ACTIVE;
              end
            end
            BANK_ACTIVE: begin
              // lockout: wait for prefetch and ras
              if (ap_r && apc_r == '0 && ras_ok) begin
                st_r <= BANK_PRECH;
              end else if (i_pre && (hit || i_pre_all) && !ap_r) begin
                st_r <= BANK_PRECH;
              end
            end
            BANK_PRECH: begin
              if (rp_r == RPW'(RP_CYC - 1)) begin
                st_r <= BANK_IDLE;
              end
            end
            default: st_r <= BANK_IDLE;
          endcase
        end
      end

      // open row is latched only on activate of an idle bank
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          row_r <= '0;
        end else if (st_r == BANK_IDLE && i_act && hit) begin
          row_r <= i_row;
        end
      end

      // ras timer saturates, precharge timer clears once the bank leaves precharge, so neither wraps
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ras_r <= '0;
          rp_r <= '0;
        end else begin
          if (st_r != BANK_ACTIVE) begin
            ras_r <= '0;
          end else if (!ras_ok) begin
            ras_r <= ras_r + RASW'(1);
          end
          if (st_r != BANK_PRECH) begin
            rp_r <= '0;
          end else begin
            rp_r <= rp_r + RPW'(1);
          end
        end
      end

      // arm from the access's own address bit only
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ap_r <= 1'b0;
          apc_r <= '0;
        end else if (st_r != BANK_ACTIVE) begin
          ap_r <= 1'b0;
          apc_r <= '0;
        end else if (i_ap && hit && !ap_r) begin
          ap_r <= 1'b1;
          apc_r <= AP_CK;
        end else if (ap_r && i_ck_rise && apc_r != '0) begin
          apc_r <= apc_r - APW'(1);
        end
      end

      assign o_open[b] = (st_r == BANK_ACTIVE);
      assign o_rows[b*ROW_W +: ROW_W] = row_r;
    end
  endgenerate

endmodule
`default_nettype wire

/* File: verilog/ddr_bank_read_refresh_control.sv */
/*
  command side of a four-bank double-data-rate memory device: command
  decode, bank tracking, read bursts with strobe, burst stop, auto and
  self refresh with dll relock.
  assumes the core clock is much faster than the link clock, which is
  sampled like any pin; write data transfer is not modelled.
*/
`default_nettype none
module ddr_bank_read_refresh_control
  import ddr_dev_pkg::*;
#(
  parameter int BL = 4,                      // burst length, 2/4/8
  parameter int CAS_HALF = 4,                // cas latency, half clocks
  parameter int SREF_TICK_CYC = REF_TICK_CYC // self refresh row period
)(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ck,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [BANK_W-1:0] i_ba,
  input wire logic [ROW_W-1:0] i_addr,
  output logic [DQ_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_dqs,
  output logic o_dqs_oe,
  output logic o_dll_en,
  output logic o_dll_locked,
  output logic o_self_refresh,
  output logic [BANK_W-1:0] o_ref_bank,
  output logic [ROW_W-1:0] o_ref_row,
  output logic [NBANK-1:0] o_bank_open
);

  localparam int LB = $clog2(BL);                 // burst index bits
  localparam int TW = $clog2(SREF_TICK_CYC + 1);  // tick counter width
  localparam int RW = $clog2(DLL_RELOCK_CK + 1);  // relock counter

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // next column, wrapping inside the burst-aligned block
  function automatic logic [COL_W-1:0] col_step(
    input logic [COL_W-1:0] col
  );
    col_step = {col[COL_W-1:LB], col[LB-1:0] + LB'(1)};
  endfunction

  // array contents: writes are not modelled, so data is a pattern
  function automatic logic [DQ_W-1:0] elem(
    input logic [BANK_W-1:0] bank,
    input logic [ROW_W-1:0] row,
    input logic [COL_W-1:0] col
  );
    elem = row[DQ_W-1:0] ^ col[DQ_W-1:0] ^ DQ_W'(bank);
  endfunction

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r; // first stage, read only by the second
  logic rst_n_s;    // released reset used everywhere else

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r; // metastability stage
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_s3_r;
  logic [PIN_W-1:0] pin_f_r;  // accepted pin levels
  logic [PIN_W-1:0] pin_dis;  // stages two and three disagree

  assign pin_raw = {i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
                    i_ba, i_addr};
  assign pin_dis = pin_s2_r ^ pin_s3_r;

  // a level counts only once two late stages agree, which filters
  // a single sample caught mid-transition
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_f_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s3_r & ~pin_dis) | (pin_f_r & pin_dis);
    end
  end

  // ------------------------------------------------------------
  // link clock edges and command decode
  // ------------------------------------------------------------
  logic ck_prev_r; // link clock level one core cycle ago
  logic cke_reg_r; // clock enable seen at the previous rise
  logic ck_rise;
  logic ck_edge;
  logic cke_now;
  logic [3:0] cmd;
  logic [BANK_W-1:0] ba;
  logic [ROW_W-1:0] addr;
  logic cmd_v;
  logic is_rd;
  logic is_wr;
  logic bst_ok;
  logic push;
  logic last_rd_ap_r; // latest read carried auto precharge
  pwr_st_t pwr_r;
  logic [NBANK-1:0] open;
  logic [NBANK*ROW_W-1:0] rows;

  assign ck_rise = pin_f_r[PIN_CK] & ~ck_prev_r;
  assign ck_edge = pin_f_r[PIN_CK] ^ ck_prev_r;
  assign cke_now = pin_f_r[PIN_CKE];
  assign cmd = pin_f_r[PIN_CMD -: 4];
  assign ba = pin_f_r[PIN_BA +: BANK_W];
  assign addr = pin_f_r[PIN_ADDR +: ROW_W];
  // inputs other than clock enable are ignored in self refresh
  assign cmd_v = ck_rise && (pwr_r != PWR_SREF);
  // reads take the open bank as soon as it is active
  assign is_rd = cmd_v && cmd == CMD_READ && open[ba];
  assign is_wr = cmd_v && cmd == CMD_WRITE && open[ba];
  // burst stop is ignored only after a read with auto precharge
  assign bst_ok = cmd_v && cmd == CMD_BST && !last_rd_ap_r;
  assign push = is_rd || bst_ok;

  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ck_prev_r <= 1'b0;
      cke_reg_r <= 1'b0;
    end else begin
      ck_prev_r <= pin_f_r[PIN_CK];
      if (ck_rise) begin
        cke_reg_r <= cke_now;
      end
    end
  end

  // remember auto precharge of the latest read for burst stop
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      last_rd_ap_r <= 1'b0;
    end else if (is_rd) begin
      last_rd_ap_r <= addr[AP_BIT];
    end
  end

  // ------------------------------------------------------------
  // bank state
  // ------------------------------------------------------------
  bank_tracker #(
    .BL(BL)
  ) u_banks (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n_s),
    .i_ck_rise(ck_rise),
    .i_act(cmd_v && cmd == CMD_ACT),
    .i_pre(cmd_v && cmd == CMD_PRE),
    .i_pre_all(addr[AP_BIT]),
    .i_ap((is_rd || is_wr) && addr[AP_BIT]),
    .i_bank(ba),
    .i_row(addr),
    .o_open(open),
    .o_rows(rows)
  );

  assign o_bank_open = open;

  // ------------------------------------------------------------
  // read latency line, one slot per link clock edge
  // ------------------------------------------------------------
  logic dl_v_r [CAS_HALF];               // slot holds an event
  logic dl_stop_r [CAS_HALF];            // event is a burst stop
  logic [BANK_W-1:0] dl_bank_r [CAS_HALF];
  logic [ROW_W-1:0] dl_row_r [CAS_HALF];
  logic [COL_W-1:0] dl_col_r [CAS_HALF];

  // a stop travels the same line as reads, so it lands exactly
  // cas latency after its command
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      for (int i = 0; i < CAS_HALF; i++) begin
        dl_v_r[i] <= 1'b0;
        dl_stop_r[i] <= 1'b0;
        dl_bank_r[i] <= '0;
        dl_row_r[i] <= '0;
        dl_col_r[i] <= '0;
      end
    end else if (ck_edge) begin
      for (int i = 0; i < CAS_HALF - 1; i++) begin
        dl_v_r[i] <= dl_v_r[i+1];
        dl_stop_r[i] <= dl_stop_r[i+1];
        dl_bank_r[i] <= dl_bank_r[i+1];
        dl_row_r[i] <= dl_row_r[i+1];
        dl_col_r[i] <= dl_col_r[i+1];
      end
      dl_v_r[CAS_HALF-1] <= push;
      dl_stop_r[CAS_HALF-1] <= bst_ok;
      dl_bank_r[CAS_HALF-1] <= ba;
      dl_row_r[CAS_HALF-1] <= rows[ba*ROW_W +: ROW_W];
      dl_col_r[CAS_HALF-1] <= addr[COL_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // burst output
  // ------------------------------------------------------------
  logic [LB-1:0] left_r;        // elements still to send
  logic [BANK_W-1:0] cur_bank_r;
  logic [ROW_W-1:0] cur_row_r;
  logic [COL_W-1:0] cur_col_r;  // column of the next element
  logic pre_due;                // a read lands within one clock

  // needs cas latency of at least three half clocks
  assign pre_due = (dl_v_r[1] && !dl_stop_r[1]) ||
                   (dl_v_r[2] && !dl_stop_r[2]);

  // a landing read always wins, so a new read cuts or joins the
  // running burst with no gap
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_dqs <= 1'b0;
      o_dqs_oe <= 1'b0;
      left_r <= '0;
      cur_bank_r <= '0;
      cur_row_r <= '0;
      cur_col_r <= '0;
    end else if (pwr_r == PWR_SREF) begin
      o_dq_oe <= 1'b0;
      o_dqs_oe <= 1'b0;
      left_r <= '0;
    end else if (ck_edge) begin
      if (dl_v_r[0] && !dl_stop_r[0]) begin
        // first element, strobe edge-aligned high
        o_dq <= elem(dl_bank_r[0], dl_row_r[0], dl_col_r[0]);
        o_dq_oe <= 1'b1;
        o_dqs <= 1'b1;
        o_dqs_oe <= 1'b1;
        left_r <= LB'(BL - 1);
        cur_bank_r <= dl_bank_r[0];
        cur_row_r <= dl_row_r[0];
        cur_col_r <= col_step(dl_col_r[0]);
      end else if (dl_v_r[0]) begin
        // truncated by burst stop: release at once
        left_r <= '0;
        o_dq_oe <= 1'b0;
        o_dqs <= 1'b0;
        o_dqs_oe <= 1'b0;
      end else if (left_r != '0) begin
        // later elements on every edge; last one has strobe low
        o_dq <= elem(cur_bank_r, cur_row_r, cur_col_r);
        o_dqs <= ~o_dqs;
        left_r <= left_r - LB'(1);
        cur_col_r <= col_step(cur_col_r);
      end else if (pre_due) begin
        // preamble: strobe driven low one clock before data
        o_dq_oe <= 1'b0;
        o_dqs <= 1'b0;
        o_dqs_oe <= 1'b1;
      end else begin
        // nothing pending: let the lines float
        o_dq_oe <= 1'b0;
        o_dqs <= 1'b0;
        o_dqs_oe <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // power state: run, self refresh, dll relock
  // ------------------------------------------------------------
  logic [RW-1:0] relock_r; // link clock rises since exit

  // entry needs enable high at the previous rise, low at this one;
  // exit does not wait for a link clock edge since it may be stopped
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pwr_r <= PWR_RUN;
    end else begin
      case (pwr_r)
        PWR_RUN: begin
          if (cmd_v && cmd == CMD_AREF && cke_reg_r && !cke_now) begin
            pwr_r <= PWR_SREF;
          end
        end
        PWR_SREF: begin
          if (cke_now) begin
            pwr_r <= PWR_RELOCK;
          end
        end
        PWR_RELOCK: begin
          if (ck_rise && relock_r == RW'(DLL_RELOCK_CK - 1)) begin
            pwr_r <= PWR_RUN;
          end
        end
        default: pwr_r <= PWR_RUN;
      endcase
    end
  end

  // count link clock rises while the dll relocks
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      relock_r <= '0;
    end else if (pwr_r != PWR_RELOCK) begin
      relock_r <= '0;
    end else if (ck_rise) begin
      relock_r <= relock_r + RW'(1);
    end
  end

  // dll off only in self refresh; locked once the count is done
  assign o_dll_en = (pwr_r != PWR_SREF);
  assign o_dll_locked = (pwr_r == PWR_RUN);
  assign o_self_refresh = (pwr_r == PWR_SREF);

  // ------------------------------------------------------------
  // refresh address counter
  // ------------------------------------------------------------
  logic [TW-1:0] tick_r;                  // core cycles per row
  logic [BANK_W+ROW_W-1:0] ref_addr_r;    // next bank and row
  logic sref_tick;
  logic ref_step;

  assign sref_tick = (pwr_r == PWR_SREF) &&
                     (tick_r == TW'(SREF_TICK_CYC - 1));
  // the address pins play no part in which row is refreshed
  assign ref_step = (cmd_v && cmd == CMD_AREF) || sref_tick;

  // self refresh paces itself on the core clock, not the link clock
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      tick_r <= '0;
    end else if (pwr_r != PWR_SREF || sref_tick) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + TW'(1);
    end
  end

  // one row per command or tick; each refresh needs its own event
  always_ff @(posedge i_core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ref_addr_r <= '0;
    end else if (ref_step) begin
      ref_addr_r <= ref_addr_r + (BANK_W+ROW_W)'(1);
    end
  end

  assign o_ref_bank = ref_addr_r[BANK_W+ROW_W-1:ROW_W];
  assign o_ref_row = ref_addr_r[ROW_W-1:0];

endmodule
`default_nettype wire

/* File: verification/ddr_bank_read_refresh_control_properties.sv */
/* timing checks on the read strobe, data release and power states.
   assumes it is bound to the device top and sees its ports only. */
`default_nettype none
module ddr_brrc_props
  import ddr_dev_pkg::*;
#(parameter int BL = 4, parameter int CAS_HALF = 4,
  parameter int SREF_TICK_CYC = 20)(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cke,
  input wire logic o_dq_oe,
  input wire logic o_dqs,
  input wire logic o_dqs_oe,
  input wire logic o_dll_en,
  input wire logic o_dll_locked,
  input wire logic o_self_refresh,
  input wire logic [NBANK-1:0] o_bank_open
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // strobe low with no data for the first six core cycles of the preamble
  sequence preamble_s;
    (o_dqs_oe && !o_dqs && !o_dq_oe) [*6];
  endsequence
  // clock enable held low long enough to pass the pin filter
  sequence cke_low_s;
    !i_cke [*8];
  endsequence
  dll_sref_a: assert property (o_dll_en == !o_self_refresh)
    else $error("dll enable does not follow power state");
  relock_a: assert property (
    $fell(o_self_refresh) |-> !o_dll_locked)
    else $error("dll locked straight after exit");
  preamble_a: assert property ($rose(o_dqs_oe) |-> preamble_s)
    else $error("read preamble missing");
  dq_dqs_a: assert property (o_dq_oe |-> o_dqs_oe)
    else $error("data driven without strobe");
  dqs_hold_a: assert property (
    o_dq_oe && $changed(o_dqs) |=> $stable(o_dqs) [*2])
    else $error("data element shorter than half clock");
  release_a: assert property ($fell(o_dq_oe) |-> !o_dqs_oe)
    else $error("strobe kept after burst");
  sref_hold_a: assert property (
    cke_low_s ##0 o_self_refresh |=> o_self_refresh)
    else $error("self refresh left with enable low");
  sref_quiet_a: assert property (
    o_self_refresh |-> !o_dq_oe && o_bank_open == '0)
    else $error("activity during self refresh");
endmodule
bind ddr_bank_read_refresh_control ddr_brrc_props #(.BL(BL),
  .CAS_HALF(CAS_HALF), .SREF_TICK_CYC(SREF_TICK_CYC)) props (.i_core_clk,
  .i_rst_n, .i_cke, .o_dq_oe, .o_dqs, .o_dqs_oe, .o_dll_en, .o_dll_locked,
  .o_self_refresh, .o_bank_open);
`default_nettype wire

/* File: verification/ddr_ctrl_model.sv */
/* controller model: makes the link clock and drives commands.
   assumes the bench calls cmd only after reset is released. */
`default_nettype none
module ddr_ctrl_model
  import ddr_dev_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_ck,
  output logic o_cke,
  output logic [3:0] o_cmd,
  output logic [BANK_W-1:0] o_ba,
  output logic [ROW_W-1:0] o_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div = 2'h0; // four core cycles per half link period
  initial begin
    o_ck = 1'b0;
    o_cke = 1'b1;
    o_cmd = 4'hf;
    o_ba = 2'h0;
    o_addr = 13'h0000;
  end
  // link clock runs free: exit needs it stable first
  always @(posedge i_core_clk) begin
    div <= div + 2'h1;
    if (div == 2'h3) o_ck <= #1 ~o_ck;
  end
  // pins change on a falling link edge and hold across the rise;
  // ordering and spacing come from the caller
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba,
                     input logic [12:0] a, input bit rel, input bit ke);
    @(negedge o_ck);
    o_cmd = c;
    o_ba = ba;
    o_addr = a;
    o_cke = ke;
    @(posedge o_ck);
    if (rel) begin
      @(negedge o_ck);
      o_cmd = 4'hf; // deselect only
      o_ba = ~ba;
      o_addr = ~a;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/ddr_bank_read_refresh_control_bench.sv */
/* self-checking bench: reads, burst stop, refresh and self refresh.
   assumes the controller model and the package constants. */
`default_nettype none
module ddr_bank_read_refresh_control_bench import ddr_dev_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, ck, cke, dq_oe, dqs, dqs_oe, dll_en;
  logic lock, sref;
  logic [3:0] cmd, open;
  logic [1:0] ba, rbank;
  logic [12:0] addr, rrow;
  logic [7:0] dq;
  int fail_count = 0, total_checks = 0;
  always #20 clk = ~clk;
  ddr_ctrl_model m (.i_core_clk(clk), .o_ck(ck), .o_cke(cke), .o_cmd(cmd),
    .o_ba(ba), .o_addr(addr));
  ddr_bank_read_refresh_control #(.SREF_TICK_CYC(20)) uut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ck(ck), .i_cke(cke),
    .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
    .i_ba(ba), .i_addr(addr), .o_dq(dq), .o_dq_oe(dq_oe), .o_dqs(dqs),
    .o_dqs_oe(dqs_oe), .o_dll_en(dll_en), .o_dll_locked(lock),
    .o_self_refresh(sref), .o_ref_bank(rbank), .o_ref_row(rrow),
    .o_bank_open(open));
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // element i of a burst: column wraps inside its block of four
  function automatic logic [7:0] ex(logic [7:0] r, logic [7:0] c, int i,
                                    logic [1:0] b);
    return r ^ {c[7:2], c[1:0] + 2'(i)} ^ {6'h00, b};
  endfunction
  // sample each element mid-way, then expect the lines released
  task automatic burst(int n, logic [7:0] r, logic [7:0] c, logic [1:0] b);
    int k;
    k = 0;
    while (dq_oe !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    for (int i = 0; i < n; i++) begin
      repeat (2) @(negedge clk);
      chk(dq, ex(r, c + 8'(i & 4), i, b));
      repeat (2) @(negedge clk);
    end
    chk(dq_oe, 1'b0);
  endtask
  // open bank 1, read from column 2 so the burst wraps
  task automatic t_read();
    m.cmd(CMD_ACT, 2'h1, 13'h00a5, 1'b1, 1'b1);
    m.cmd(CMD_READ, 2'h1, 13'h0002, 1'b1, 1'b1);
    chk(open, 4'h2);
    burst(4, 8'ha5, 8'h02, 2'h1);
  endtask
  // second read two pairs later joins the full burst with no gap
  task automatic t_concat();
    m.cmd(CMD_READ, 2'h1, 13'h0000, 1'b1, 1'b1);
    m.cmd(CMD_READ, 2'h1, 13'h0004, 1'b1, 1'b1);
    burst(8, 8'ha5, 8'h00, 2'h1);
  endtask
  // stop after one pair; a stop after an auto precharge read is ignored
  task automatic t_bst();
    m.cmd(CMD_READ, 2'h1, 13'h0000, 1'b0, 1'b1);
    m.cmd(CMD_BST, 2'h1, 13'h0000, 1'b1, 1'b1);
    burst(2, 8'ha5, 8'h00, 2'h1);
    m.cmd(CMD_ACT, 2'h2, 13'h0033, 1'b0, 1'b1);
    m.cmd(CMD_READ, 2'h2, 13'h0400, 1'b0, 1'b1);
    m.cmd(CMD_BST, 2'h2, 13'h0000, 1'b1, 1'b1);
    burst(4, 8'h33, 8'h00, 2'h2);
    repeat (20) @(negedge clk);
    chk(open, 4'h2);
  endtask
  // plain refresh, self refresh with its ticks, exit and relock
  task automatic t_sref();
    logic [14:0] r0;
    m.cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1, 1'b1);
    r0 = {rbank, rrow};
    m.cmd(CMD_AREF, 2'h3, 13'h1fff, 1'b1, 1'b1);
    repeat (8) @(negedge clk);
    chk(open, 4'h0);
    chk({rbank, rrow}, r0 + 15'h1);
    m.cmd(CMD_AREF, 2'h0, 13'h0000, 1'b1, 1'b0);
    repeat (30) @(negedge clk);
    chk({sref, dll_en}, 2'b10);
    chk({rbank, rrow}, r0 + 15'h3);
    m.cmd(4'hf, 2'h0, 13'h0000, 1'b1, 1'b1);
    repeat (12) @(negedge clk);
    chk({sref, lock}, 2'b00);
    // the exit rise counts as the first; land on the 200th and 201st
    repeat (198) @(posedge ck);
    chk(lock, 1'b0);
    repeat (1) @(posedge ck);
    chk(lock, 1'b1);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    t_read();
    t_concat();
    t_bst();
    t_sref();
    summarize();
  end
  // the whole run needs about 2000 core cycles
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
